// [verilog/rotdp_core.sv]
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE1: the left rotate moves each bit one place up and old bit 7 into bit 0, carry untouched.
// RULE2: the right rotate moves each bit one place down, old bit 0 into carry and old carry into bit 7.
// RULE3: destination select 0 writes the working register, 1 writes back to the file register.
// RULE4: bank access 0 uses the access bank, 1 uses the bank select register for the upper address bits.
// RULE5: bank access 0 with extended set on and operand at most 95 uses index-plus-literal addressing.
// RULE6: file operands 0 to 255 are accepted, destination and access selects are single bits.
// RULE7: negative follows result bit 7, zero is set for an all-zero result, one cycle per rotate.
module rotdp_core (
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_N_IN,
  input  wire logic                    INSTR_VALID_IN,
  input  wire rotdp_pkg::rotdp_instr_t INSTR_IN,
  input  wire logic                    EXT_SET_EN_IN,
  input  wire logic [3:0]              BANK_SELECT_REGISTER_IN,
  input  wire logic [11:0]             INDEX_BASE_IN,
  input  wire logic [7:0]              RD_DATA_IN,
  output logic [11:0]                  RD_ADDR_OUT,
  output rotdp_pkg::rotdp_mem_wr_t     MEM_WR_OUT,
  output logic [7:0]                   WREG_OUT,
  output rotdp_pkg::rotdp_flags_t      FLAGS_OUT,
  output logic                         DONE_OUT
);
  import rotdp_pkg::*;

  logic [11:0]   addr;
  logic [7:0]    result;
  logic          carry_nxt;
  logic [7:0]    wreg_r, wreg_nxt;
  rotdp_flags_t  flags_r, flags_nxt;
  rotdp_mem_wr_t wr_r, wr_nxt;
  logic          done_r, done_nxt;
  logic          go;

  assign go = INSTR_VALID_IN && (INSTR_IN.op != ROTDP_OP_NONE);

  // bank select only enters when bank access is set; the access bank splits at the
  // split constant into low file space and the special-function page
  // full 8-bit operand space is decoded, so every f from 0 to 255 is legal [RULE6]
  always_comb begin
    if (INSTR_IN.bank_acc) begin
      addr = {BANK_SELECT_REGISTER_IN, INSTR_IN.file_addr}; // [RULE4]
    end else if (EXT_SET_EN_IN && (INSTR_IN.file_addr <= ROTDP_ACCESS_LIMIT)) begin
      addr = INDEX_BASE_IN + {4'h0, INSTR_IN.file_addr}; // [RULE5]
    end else if (INSTR_IN.file_addr < ROTDP_ACCESS_SPLIT) begin
      addr = {4'h0, INSTR_IN.file_addr}; // [RULE4]
    end else begin
      addr = {ROTDP_SFR_BANK, INSTR_IN.file_addr}; // [RULE4]
    end
  end

  assign RD_ADDR_OUT = addr;

  // carry is taken from the registered flag, so each right rotate sees the carry
  // left by the one before, even back to back
  always_comb begin
    result    = RD_DATA_IN;
    carry_nxt = flags_r.carry;
    case (INSTR_IN.op)
      ROTDP_OP_RLNC: begin
        result = {RD_DATA_IN[6:0], RD_DATA_IN[7]}; // [RULE1]
      end
      ROTDP_OP_RRC: begin
        result    = {flags_r.carry, RD_DATA_IN[7:1]}; // [RULE2]
        carry_nxt = RD_DATA_IN[0]; // [RULE2]
      end
      default: begin
        result = RD_DATA_IN;
      end
    endcase
  end

  // refused cycles keep the working register and flags; the write strobe falls
  // every cycle so a single rotate can never write twice
  always_comb begin
    wreg_nxt  = wreg_r;
    flags_nxt = flags_r;
    wr_nxt    = '0;
    done_nxt  = 1'b0;
    if (go) begin
      done_nxt = 1'b1; // single-cycle completion [RULE7]
      flags_nxt.carry    = carry_nxt;
      flags_nxt.negative = result[7]; // [RULE7]
      flags_nxt.zero     = (result == 8'h00); // [RULE7]
      if (INSTR_IN.dest_sel) begin
        wr_nxt.wr_en = 1'b1; // [RULE3]
        wr_nxt.addr  = addr;
        wr_nxt.data  = result;
      end else begin
        wreg_nxt = result; // [RULE3]
      end
    end
  end

  // reset clears flags as a whole, so the first right rotate never shifts in an unknown carry
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wreg_r  <= ROTDP_W_RESET;
      flags_r <= '{carry: ROTDP_CARRY_RESET, negative: 1'b0, zero: 1'b0};
      wr_r    <= '0;
      done_r  <= 1'b0;
    end else begin
      wreg_r  <= wreg_nxt;
      flags_r <= flags_nxt;
      wr_r    <= wr_nxt;
      done_r  <= done_nxt;
    end
  end

  assign WREG_OUT   = wreg_r;
  assign FLAGS_OUT  = flags_r;
  assign MEM_WR_OUT = wr_r;
  assign DONE_OUT   = done_r;

  // file writes land one cycle after the read, so back-to-back rotates on the
  // same register need the memory to forward; the decoder must stall otherwise

  // results and carry
  rlnc_result_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE1]
    (go && INSTR_IN.op == ROTDP_OP_RLNC && INSTR_IN.dest_sel) |=>
      MEM_WR_OUT.data == {$past(RD_DATA_IN[6:0]), $past(RD_DATA_IN[7])})
    else $error("left rotate result wrong");

  rlnc_carry_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE1]
    (go && INSTR_IN.op == ROTDP_OP_RLNC) |=> $stable(FLAGS_OUT.carry))
    else $error("left rotate changed carry");

  rrc_result_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE2]
    (go && INSTR_IN.op == ROTDP_OP_RRC && !INSTR_IN.dest_sel) |=>
      WREG_OUT == {$past(FLAGS_OUT.carry), $past(RD_DATA_IN[7:1])})
    else $error("right rotate result wrong");

  rrc_carry_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE2]
    (go && INSTR_IN.op == ROTDP_OP_RRC) |=> FLAGS_OUT.carry == $past(RD_DATA_IN[0]))
    else $error("right rotate carry wrong");

  rlnc_wreg_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE1]
    (go && INSTR_IN.op == ROTDP_OP_RLNC && !INSTR_IN.dest_sel) |=>
      WREG_OUT == {$past(RD_DATA_IN[6:0]), $past(RD_DATA_IN[7])})
    else $error("left rotate working result wrong");

  rrc_file_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE2]
    (go && INSTR_IN.op == ROTDP_OP_RRC && INSTR_IN.dest_sel) |=>
      MEM_WR_OUT.data == {$past(FLAGS_OUT.carry), $past(RD_DATA_IN[7:1])})
    else $error("right rotate file result wrong");

  carry_kept_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE1]
    ($past(RST_N_IN) && $changed(FLAGS_OUT.carry)) |->
      $past(go && INSTR_IN.op == ROTDP_OP_RRC))
    else $error("carry moved without a right rotate");

  // destination and write strobe
  dest_file_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE3]
    (go && INSTR_IN.dest_sel) |=> MEM_WR_OUT.wr_en && $stable(WREG_OUT)
      && MEM_WR_OUT.addr == $past(RD_ADDR_OUT))
    else $error("file destination not written");

  dest_wreg_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE3]
    (go && !INSTR_IN.dest_sel) |=> !MEM_WR_OUT.wr_en)
    else $error("working destination wrote memory");

  wr_source_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE3]
    MEM_WR_OUT.wr_en |-> $past(go && INSTR_IN.dest_sel))
    else $error("file write without a rotate to the file");

  wreg_kept_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE3]
    ($past(RST_N_IN) && $changed(WREG_OUT)) |-> $past(go && !INSTR_IN.dest_sel))
    else $error("working register moved without a rotate to it");

  // operand address forming, then the n and z flag check
  bank_addr_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE4]
    (INSTR_IN.bank_acc) |-> RD_ADDR_OUT == {BANK_SELECT_REGISTER_IN, INSTR_IN.file_addr})
    else $error("banked address wrong");

  indexed_addr_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE5]
    (!INSTR_IN.bank_acc && EXT_SET_EN_IN && INSTR_IN.file_addr <= 8'h5f) |->
      RD_ADDR_OUT == INDEX_BASE_IN + {4'h0, INSTR_IN.file_addr})
    else $error("indexed address wrong");

  access_low_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE4]
    (!INSTR_IN.bank_acc && !(EXT_SET_EN_IN && INSTR_IN.file_addr <= ROTDP_ACCESS_LIMIT)
      && INSTR_IN.file_addr < ROTDP_ACCESS_SPLIT) |-> RD_ADDR_OUT == {4'h0, INSTR_IN.file_addr})
    else $error("access bank low address wrong");

  access_high_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE4]
    (!INSTR_IN.bank_acc && !(EXT_SET_EN_IN && INSTR_IN.file_addr <= ROTDP_ACCESS_LIMIT)
      && INSTR_IN.file_addr >= ROTDP_ACCESS_SPLIT) |-> RD_ADDR_OUT == {ROTDP_SFR_BANK, INSTR_IN.file_addr})
    else $error("access bank high address wrong");

  offset_byte_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE6]
    (INSTR_IN.bank_acc || !EXT_SET_EN_IN || INSTR_IN.file_addr > ROTDP_ACCESS_LIMIT) |->
      RD_ADDR_OUT[7:0] == INSTR_IN.file_addr)
    else $error("operand byte lost from address");

  flags_nz_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE7]
    go |=> DONE_OUT && FLAGS_OUT.negative == $past(result[7])
      && FLAGS_OUT.zero == ($past(result) == 8'h00))
    else $error("n or z flag wrong");

  // flags, completion and reset
  refused_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE7]
    !go |=> !DONE_OUT && !MEM_WR_OUT.wr_en && $stable(WREG_OUT) && $stable(FLAGS_OUT))
    else $error("refused cycle changed state");

  rlnc_flags_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE7]
    (go && INSTR_IN.op == ROTDP_OP_RLNC) |=> FLAGS_OUT.negative == $past(RD_DATA_IN[6])
      && FLAGS_OUT.zero == ($past(RD_DATA_IN) == 8'h00))
    else $error("left rotate n or z flag wrong");

  rrc_flags_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RULE7]
    (go && INSTR_IN.op == ROTDP_OP_RRC) |=> FLAGS_OUT.negative == $past(FLAGS_OUT.carry)
      && FLAGS_OUT.zero == (!$past(FLAGS_OUT.carry) && $past(RD_DATA_IN[7:1]) == 7'h00))
    else $error("right rotate n or z flag wrong");

  reset_clear_a: assert property (@(posedge CLK_IN) // [RULE7]
    !RST_N_IN |=> WREG_OUT == ROTDP_W_RESET && FLAGS_OUT.carry == ROTDP_CARRY_RESET
      && !FLAGS_OUT.negative && !FLAGS_OUT.zero && !MEM_WR_OUT.wr_en && !DONE_OUT)
    else $error("reset left state behind");

endmodule : rotdp_core

`default_nettype wire

// [verilog/rotdp_pkg.sv]
package rotdp_pkg;

  localparam logic [7:0] ROTDP_ACCESS_LIMIT  = 8'h5f;
  localparam logic [7:0] ROTDP_W_RESET       = 8'h00;
  localparam logic       ROTDP_CARRY_RESET   = 1'b0;
  localparam logic [3:0] ROTDP_BANKSEL_RESET = 4'h0;
  localparam logic [7:0] ROTDP_ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0] ROTDP_SFR_BANK      = 4'hf;

  typedef enum logic [1:0] {
    ROTDP_OP_NONE,
    ROTDP_OP_RLNC,
    ROTDP_OP_RRC
  } rotdp_op_t;

  typedef struct packed {
    rotdp_op_t  op;
    logic       dest_sel;
    logic       bank_acc;
    logic [7:0] file_addr;
  } rotdp_instr_t;

  typedef struct packed {
    logic        wr_en;
    logic [11:0] addr;
    logic [7:0]  data;
  } rotdp_mem_wr_t;

  typedef struct packed {
    logic carry;
    logic negative;
    logic zero;
  } rotdp_flags_t;

endpackage : rotdp_pkg

// [tb/rotdp_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module rotdp_mem_model
  import rotdp_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic [11:0]   rd_addr_in,
  input  wire rotdp_mem_wr_t wr_in,
  output logic [7:0]         rd_data_out
);
  logic [7:0] mem [4096];
  // a write still in flight is forwarded, as the file would show it
  assign rd_data_out = (wr_in.wr_en && wr_in.addr == rd_addr_in) ? wr_in.data : mem[rd_addr_in];
  always @(posedge clk_in) if (wr_in.wr_en) mem[wr_in.addr] <= wr_in.data;
endmodule : rotdp_mem_model
`default_nettype wire

// [tb/test_rotate_instruction_datapath.sv]
`timescale 1ns/1ns
`default_nettype none
module test_rotate_instruction_datapath;
  import rotdp_pkg::*;
  logic          clk = 0, rst_n = 0, valid = 0, ext = 0, done;
  logic [3:0]    bank_select_register = 4'h2;
  logic [11:0]   ibase = 12'h300, rd_addr;
  logic [7:0]    rd_data, wreg;
  rotdp_instr_t  instr = '0;
  rotdp_mem_wr_t mwr;
  rotdp_flags_t  flags;
  int            failures = 0, cmp_count = 0;
  always #25 clk = ~clk;
  rotdp_core u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid), .INSTR_IN(instr),
    .EXT_SET_EN_IN(ext), .BANK_SELECT_REGISTER_IN(bank_select_register), .INDEX_BASE_IN(ibase), .RD_DATA_IN(rd_data),
    .RD_ADDR_OUT(rd_addr), .MEM_WR_OUT(mwr), .WREG_OUT(wreg), .FLAGS_OUT(flags), .DONE_OUT(done));
  rotdp_mem_model u_mem (.clk_in(clk), .rd_addr_in(rd_addr), .wr_in(mwr), .rd_data_out(rd_data));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input rotdp_op_t op, input logic d, input logic a, input logic [7:0] f, input logic [11:0] ea);
    @(negedge clk);
    instr = '{op, d, a, f};
    valid = 1'h1;
    #1 chk(rd_addr, ea);
    @(negedge clk);
    valid = 1'h0;
    chk(done, op != ROTDP_OP_NONE);
  endtask : go
  task automatic t_right;
    u_mem.mem[12'h240] = 8'he6;
    u_mem.mem[12'h241] = 8'h01;
    go(ROTDP_OP_RRC, 1'h0, 1'h1, 8'h40, 12'h240);
    chk({wreg, flags, mwr.wr_en}, {8'h73, 3'h0, 1'h0});
    go(ROTDP_OP_RRC, 1'h0, 1'h1, 8'h41, 12'h241);
    chk({wreg, flags}, {8'h00, 3'h5});
  endtask : t_right
  task automatic t_left;
    u_mem.mem[12'h234] = 8'hab;
    u_mem.mem[12'h235] = 8'hc0;
    go(ROTDP_OP_RLNC, 1'h1, 1'h1, 8'h34, 12'h234);
    chk({mwr, flags, wreg}, {1'h1, 12'h234, 8'h57, 3'h4, 8'h00});
    go(ROTDP_OP_RLNC, 1'h0, 1'h1, 8'h35, 12'h235);
    chk({wreg, flags}, {8'h81, 3'h6});
    go(ROTDP_OP_RRC, 1'h1, 1'h1, 8'h41, 12'h241);
    chk({mwr, flags}, {1'h1, 12'h241, 8'h80, 3'h6});
  endtask : t_left
  task automatic t_addr;
    u_mem.mem[12'hf70] = 8'h00;
    u_mem.mem[12'h35f] = 8'h00;
    u_mem.mem[12'hfff] = 8'h00;
    go(ROTDP_OP_RLNC, 1'h0, 1'h0, 8'h70, 12'hf70);
    u_mem.mem[12'h020] = 8'h80;
    go(ROTDP_OP_RLNC, 1'h0, 1'h0, 8'h20, 12'h020);
    chk({wreg, flags}, {8'h01, 3'h4});
    ext = 1'h1;
    go(ROTDP_OP_RLNC, 1'h0, 1'h0, 8'h5f, 12'h35f);
    go(ROTDP_OP_RLNC, 1'h0, 1'h0, 8'hff, 12'hfff);
    chk({wreg, flags}, {8'h00, 3'h5});
    go(ROTDP_OP_NONE, 1'h0, 1'h1, 8'h41, 12'h241);
    chk({wreg, flags, mwr.wr_en}, {8'h00, 3'h5, 1'h0});
  endtask : t_addr
  task automatic t_reset;
    @(negedge clk);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    chk({wreg, flags, mwr.wr_en, done}, {8'h00, 3'h0, 1'h0, 1'h0});
    rst_n = 1'h1;
    go(ROTDP_OP_RRC, 1'h0, 1'h1, 8'h34, 12'h234);
    chk({wreg, flags}, {8'h2b, 3'h4});
  endtask : t_reset
  task automatic results;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    t_right();
    t_left();
    t_addr();
    t_reset();
    results();
  end
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule : test_rotate_instruction_datapath
`default_nettype wire
